// ===== hdl/physt_pkg.sv
// Constants and carrier types for the strap capture and condition registers.
// Assumes one 25 MHz core clock and a synchronous active-high reset.

package physt_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_STRAP = 5'h10;
  localparam logic [4:0] OFF_COND  = 5'h11;

  // ----------------------------------------------------------------
  // Strap capture register fields
  // ----------------------------------------------------------------
  localparam int SB_AN    = 15;
  localparam int SB_DUP   = 14;
  localparam int SB_SPD   = 12;
  localparam int SB_NC    = 10;
  localparam int SB_MCLK  = 7;
  localparam int SB_XOVER = 6;
  localparam int SB_MULTI = 5;
  localparam int SB_ADDR  = 0;

  // ----------------------------------------------------------------
  // Condition register fields
  // ----------------------------------------------------------------
  localparam int CB_POL   = 12;
  localparam int CB_PD    = 11;
  localparam int CB_XOVER = 10;
  localparam int CB_FIFO  = 9;
  localparam int CB_SLB   = 7;
  localparam int CB_DLB   = 6;
  localparam int CB_NCO   = 5;
  localparam int CB_SPD   = 3;
  localparam int CB_LINK  = 2;
  localparam int CB_FDX   = 1;
  localparam int CB_MST   = 0;

  // ----------------------------------------------------------------
  // Types and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       an_enable;
    logic       duplex;
    logic [1:0] speed;
    logic       nc_mode;
    logic       mac_clk_enable;
    logic       auto_crossover_strap;
    logic       multi_port;
    logic [4:0] station_address_straps;
  } physt_strap_t;

  typedef struct packed {
    logic [3:0] pair_polarity_flags;
    logic       power_down;
    logic       crossover_state;
    logic       fifo_overflow;
    logic       fifo_underrun;
    logic       shallow_loopback;
    logic       deep_loopback;
    logic       nc_only;
    logic [1:0] speed;
    logic       link_up;
    logic       full_duplex;
    logic       master;
  } physt_cond_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } physt_req_t;

  localparam physt_strap_t STRAP_RST = 13'h18c1;
  localparam logic [15:0]  RDATA_RST = 16'h0000;

endpackage

// ===== hdl/physt_sync.sv
// Two-stage synchroniser for the strap pins.
// Assumes the pins are quasi-static levels from outside the clock domain.

`timescale 1ns/10ps

module physt_sync
  import physt_pkg::*;
(
  // Clock
  input  wire logic         clk,
  // Pin levels in, synchronised levels out
  input  wire physt_strap_t d,
  output physt_strap_t      q
);

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // No reset here: the chain must keep tracking the pins during reset.
  physt_strap_t meta_r;

  always_ff @(posedge clk)
  begin
    meta_r <= d;
  end

  always_ff @(posedge clk)
  begin
    q <= meta_r;
  end

endmodule

// ===== hdl/physt_sticky.sv
// Sticky flag: set by an event, cleared by a second event.
// Assumes set and clear come from logic on the same clock.

`timescale 1ns/10ps

module physt_sticky
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Events
  input  wire logic set,
  input  wire logic clr,
  // Flag
  output logic      flag_r
);

  // ----------------------------------------------------------------
  // Flag
  // ----------------------------------------------------------------
  // A set in the clearing cycle wins, so no error is ever lost.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flag_r <= 1'b0;
    end
    else if (set)
    begin
      flag_r <= 1'b1;
    end
    else if (clr)
    begin
      flag_r <= 1'b0;
    end
  end

endmodule

// ===== hdl/physt_regs.sv
// Strap capture and condition registers of the transceiver.
// Assumes strap pins are asynchronous and core condition inputs share clk.
//
// Function
// - Strap capture register is read-only; only restrap plus reset changes it.
// - Bit 15 holds autonegotiation strap, default for control bit 12.
// - Bit 14 holds duplex strap, default for control bit 8.
// - Bits 13:12 hold speed straps, default 00, for control bits 6, 13.
// - Bit 10 holds non-compliant strap, default for bit 9 of 0x12.
// - Bit 7 holds the MAC clock output enable strap.
// - Bit 6 holds auto crossover strap, default for bit 15 of 0x12.
// - Bit 5 holds multi-port strap, default for bit 10 of 0x09.
// - Bits 4:0 hold station address straps, default 00001.
// - Reserved bits read zero; software writes zero and ignores them.
// - Condition bits 15:12 flag reversed polarity on pairs A to D.
// - Condition bit 11 reads one during power down.
// - Condition bit 10 shows actual pairing, one for cross-over.
// - Condition bit 9 sets on FIFO overflow or underrun, clears on link loss.
// - Condition bit 7 reads one during shallow loopback.
// - Condition bit 6 reads one during deep loopback.
// - Condition bit 5 reads one when detecting only non-compliant mode.
// - Condition bits 4:3 give resolved speed: 10, 01, 00; 11 reserved.
// - Condition bit 2 reads one with a good link.
// - Condition bit 1 reads one in full duplex.
// - Condition bit 0 reads one as master.

`timescale 1ns/10ps

module physt_regs
  import physt_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Strap pins, asynchronous levels
  input  wire physt_strap_t strap_pins,
  // Core condition, on clk
  input  wire physt_cond_t  cond_in,
  // Register port
  input  wire physt_req_t   req,
  output logic [15:0]       rdata_r,
  // Captured straps, used as control register reset defaults
  output physt_strap_t      strap_r
);

  // ----------------------------------------------------------------
  // Word assembly
  // ----------------------------------------------------------------
  function automatic logic [15:0] strap_word(input physt_strap_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[SB_AN] = s.an_enable;
    w[SB_DUP] = s.duplex;
    w[SB_SPD+:2] = s.speed;
    w[SB_NC] = s.nc_mode;
    w[SB_MCLK] = s.mac_clk_enable;
    w[SB_XOVER] = s.auto_crossover_strap;
    w[SB_MULTI] = s.multi_port;
    w[SB_ADDR+:5] = s.station_address_straps;
    return w;
  endfunction

  // Power down shares the reserved slot 11; it is a real state bit.
  function automatic logic [15:0] cond_word(input physt_cond_t c, input logic fe);
    logic [15:0] w;
    w = 16'h0000;
    w[CB_POL+:4] = c.pair_polarity_flags;
    w[CB_PD] = c.power_down;
    w[CB_XOVER] = c.crossover_state;
    w[CB_FIFO] = fe;
    w[CB_SLB] = c.shallow_loopback;
    w[CB_DLB] = c.deep_loopback;
    w[CB_NCO] = c.nc_only;
    w[CB_SPD+:2] = c.speed;
    w[CB_LINK] = c.link_up;
    w[CB_FDX] = c.full_duplex;
    w[CB_MST] = c.master;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  physt_strap_t pins_s;
  logic         rst_q;
  logic         release_s;

  physt_sync u_sync
  (
    .clk (clk),
    .d   (strap_pins),
    .q   (pins_s)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rst_q <= 1'b1;
    end
    else
    begin
      rst_q <= 1'b0;
    end
  end

  assign release_s = rst_q & ~rst;

  // Writes never reach this register; only reset and a new capture change it.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strap_r <= STRAP_RST;
    end
    else if (release_s)
    begin
      strap_r <= pins_s;
    end
  end

  // ----------------------------------------------------------------
  // Condition tracking
  // ----------------------------------------------------------------
  physt_cond_t cond_r;
  logic        fifo_err;
  logic        fifo_evt;
  logic        link_lost;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cond_r <= '0;
    end
    else
    begin
      cond_r <= cond_in;
    end
  end

  assign fifo_evt  = cond_in.fifo_overflow | cond_in.fifo_underrun;
  assign link_lost = cond_r.link_up & ~cond_in.link_up;

  physt_sticky u_fifo_err
  (
    .clk    (clk),
    .rst    (rst),
    .set    (fifo_evt),
    .clr    (link_lost),
    .flag_r (fifo_err)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stand for exactly one cycle; writes are accepted and dropped.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_r <= RDATA_RST;
    end
    else if (req.rd)
    begin
      case (req.addr)
        OFF_STRAP: rdata_r <= strap_word(strap_r);
        OFF_COND:  rdata_r <= cond_word(cond_r, fifo_err);
        default:   rdata_r <= RDATA_RST;
      endcase
    end
    else
    begin
      rdata_r <= RDATA_RST;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_release;
    rst_q && !rst;
  endsequence

  sequence s_rd_strap;
    req.rd && req.addr == OFF_STRAP;
  endsequence

  sequence s_rd_cond;
    req.rd && req.addr == OFF_COND;
  endsequence

  strap_default_a: assert property (disable iff (1'b0) rst |=> strap_r == STRAP_RST)
    else $error("strap register missed its reset default");

  strap_hold_a: assert property (!rst_q && (req.wr || req.rd) |=> $stable(strap_r))
    else $error("strap register changed after capture");

  an_capture_a: assert property (s_release |=> strap_r.an_enable == $past(pins_s.an_enable))
    else $error("autonegotiation strap not captured");

  dup_capture_a: assert property (s_release |=> strap_r.duplex == $past(pins_s.duplex))
    else $error("duplex strap not captured");

  spd_capture_a: assert property (s_release |=> strap_r.speed == $past(pins_s.speed))
    else $error("speed straps not captured");

  nc_capture_a: assert property (s_release |=> strap_r.nc_mode == $past(pins_s.nc_mode))
    else $error("non-compliant strap not captured");

  mclk_capture_a: assert property (s_release ##1 s_rd_strap |=>
    rdata_r[SB_MCLK] == $past(pins_s.mac_clk_enable, 2))
    else $error("clock output strap not reported");

  xover_capture_a: assert property (s_release |=>
    strap_r.auto_crossover_strap == $past(pins_s.auto_crossover_strap))
    else $error("crossover strap not captured");

  multi_capture_a: assert property (s_release |=> strap_r.multi_port == $past(pins_s.multi_port))
    else $error("multi-port strap not captured");

  addr_capture_a: assert property (s_release |=>
    strap_r.station_address_straps == $past(pins_s.station_address_straps))
    else $error("station address straps not captured");

  strap_resv_a: assert property (s_rd_strap |=> rdata_r[11] == 1'b0 && rdata_r[9:8] == 2'h0)
    else $error("strap reserved bits not zero");

  cond_resv_a: assert property (s_rd_cond |=> rdata_r[8] == 1'b0)
    else $error("condition reserved bit not zero");

  pol_read_a: assert property (cond_in.pair_polarity_flags == 4'ha ##1 s_rd_cond |=> rdata_r[15:12] == 4'ha)
    else $error("pair polarity flags misreported");

  pd_read_a: assert property (s_rd_cond |=> rdata_r[CB_PD] == $past(cond_r.power_down))
    else $error("power down state misreported");

  xover_read_a: assert property (cond_in.crossover_state ##1 s_rd_cond |=> rdata_r[CB_XOVER])
    else $error("crossover state misreported");

  fifo_set_a: assert property (fifo_evt ##1 s_rd_cond |=> rdata_r[CB_FIFO])
    else $error("fifo error not flagged");

  fifo_clr_a: assert property (link_lost && !fifo_evt ##1 (!fifo_evt and s_rd_cond) |=> !rdata_r[CB_FIFO])
    else $error("fifo error not cleared on link loss");

  slb_read_a: assert property (s_rd_cond |=> rdata_r[CB_SLB] == $past(cond_r.shallow_loopback))
    else $error("shallow loopback misreported");

  dlb_read_a: assert property (s_rd_cond |=> rdata_r[CB_DLB] == $past(cond_r.deep_loopback))
    else $error("deep loopback misreported");

  nco_read_a: assert property (s_rd_cond |=> rdata_r[CB_NCO] == $past(cond_r.nc_only))
    else $error("non-compliant detect misreported");

  spd_read_a: assert property (cond_in.speed == 2'h2 ##1 s_rd_cond |=> rdata_r[CB_SPD+:2] == 2'h2)
    else $error("resolved speed misreported");

  link_read_a: assert property (s_rd_cond |=> rdata_r[CB_LINK] == $past(cond_r.link_up))
    else $error("link state misreported");

  fdx_read_a: assert property (s_rd_cond |=> rdata_r[CB_FDX] == $past(cond_r.full_duplex))
    else $error("duplex state misreported");

  mst_read_a: assert property (s_rd_cond |=> rdata_r[CB_MST] == $past(cond_r.master))
    else $error("master state misreported");

  read_quiet_a: assert property (s_rd_cond ##1 !fifo_evt && !link_lost |=> fifo_err == $past(fifo_err))
    else $error("read disturbed the fifo error flag");

  idle_zero_a: assert property (!req.rd |=> rdata_r == RDATA_RST)
    else $error("read data outside the answer cycle");

  // ----------------------------------------------------------------
  // Field read checks
  // ----------------------------------------------------------------
  // A read shows the register as it stood at the edge that took the strobe.
  sequence s_rd_other;
    req.rd && req.addr != OFF_STRAP && req.addr != OFF_COND;
  endsequence

  an_read_a: assert property (s_rd_strap |=> rdata_r[SB_AN] == $past(strap_r.an_enable))
    else $error("autonegotiation strap misreported");

  dup_read_a: assert property (s_rd_strap |=> rdata_r[SB_DUP] == $past(strap_r.duplex))
    else $error("duplex strap misreported");

  spd_strap_a: assert property (s_rd_strap |=> rdata_r[SB_SPD+:2] == $past(strap_r.speed))
    else $error("speed straps misreported");

  nc_read_a: assert property (s_rd_strap |=> rdata_r[SB_NC] == $past(strap_r.nc_mode))
    else $error("non-compliant strap misreported");

  mclk_read_a: assert property (s_rd_strap |=> rdata_r[SB_MCLK] == $past(strap_r.mac_clk_enable))
    else $error("clock output strap misreported");

  xstrap_read_a: assert property (s_rd_strap |=> rdata_r[SB_XOVER] == $past(strap_r.auto_crossover_strap))
    else $error("crossover strap misreported");

  multi_read_a: assert property (s_rd_strap |=> rdata_r[SB_MULTI] == $past(strap_r.multi_port))
    else $error("multi-port strap misreported");

  addr_read_a: assert property (s_rd_strap |=> rdata_r[SB_ADDR+:5] == $past(strap_r.station_address_straps))
    else $error("station address straps misreported");

  pol_exact_a: assert property (s_rd_cond |=> rdata_r[CB_POL+:4] == $past(cond_r.pair_polarity_flags))
    else $error("pair polarity field misreported");

  xover_exact_a: assert property (s_rd_cond |=> rdata_r[CB_XOVER] == $past(cond_r.crossover_state))
    else $error("crossover field misreported");

  fifo_read_a: assert property (s_rd_cond |=> rdata_r[CB_FIFO] == $past(fifo_err))
    else $error("fifo error field misreported");

  spd_exact_a: assert property (s_rd_cond |=> rdata_r[CB_SPD+:2] == $past(cond_r.speed))
    else $error("resolved speed field misreported");

  other_zero_a: assert property (s_rd_other |=> rdata_r == RDATA_RST)
    else $error("unmapped read returned data");

  write_quiet_a: assert property (req.wr |=> rdata_r == RDATA_RST)
    else $error("write produced read data");

  // ----------------------------------------------------------------
  // Flag and capture checks
  // ----------------------------------------------------------------
  sequence s_fifo_race;
    fifo_evt && link_lost;
  endsequence

  fifo_now_a: assert property (fifo_evt |=> fifo_err)
    else $error("fifo event did not set the flag");

  fifo_win_a: assert property (s_fifo_race |=> fifo_err)
    else $error("link loss beat a fifo event");

  fifo_keep_a: assert property (!fifo_evt && !link_lost |=> $stable(fifo_err))
    else $error("fifo flag moved without an event");

  fifo_reset_a: assert property (disable iff (1'b0) rst |=> !fifo_err)
    else $error("fifo flag survived reset");

  rdata_reset_a: assert property (disable iff (1'b0) rst |=> rdata_r == RDATA_RST)
    else $error("read data not cleared by reset");

  strap_still_a: assert property (!rst_q |=> $stable(strap_r))
    else $error("straps changed outside a capture");

  cond_track_a: assert property (1'b1 |=> cond_r == $past(cond_in))
    else $error("condition copy lags the core");

endmodule

// ===== tb/physt_mgmt.sv
// Management controller model that reads and writes the register port.
// Assumes the caller waits until reset is released before calling a task.

`timescale 1ns/10ps

module physt_mgmt
  import physt_pkg::*;
(
  // Clock
  input  wire logic         clk,
  // Register port
  output physt_req_t        req,
  input  wire logic [15:0]  rdata_r
);
  initial req = '0;

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Released lines carry the inverse of the last value, so a design that
  // samples them outside a strobe cannot pass by luck.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '{addr: ~a, wdata: 16'hffff, wr: 1'b0, rd: 1'b0};
    @(posedge clk);
    d = rdata_r;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    logic [15:0] m;
    m = (a == OFF_STRAP) ? 16'hf4ff : (a == OFF_COND) ? 16'hfeff : 16'hffff;
    @(posedge clk);
    req <= '{addr: a, wdata: w & m, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: ~a, wdata: ~(w & m), wr: 1'b0, rd: 1'b0};
  endtask
endmodule

// ===== tb/test_physt_regs.sv
// Self-checking bench for the strap capture and condition registers.
// Assumes the management model in physt_mgmt drives the register port.

`timescale 1ns/10ps

module test_physt_regs
  import physt_pkg::*;
;
  logic         clk;
  logic         rst;
  physt_strap_t strap_pins;
  physt_cond_t  cond_in;
  physt_req_t   req;
  logic [15:0]  rdata_r;
  physt_strap_t strap_r;
  int           errors;
  int           checks_done;
  int           cycles = 0;
  int           i;
  logic [31:0]  seed;
  logic [15:0]  d;
  physt_strap_t p;
  physt_cond_t  c;

  initial clk = 1'b0;
  always #20 clk = ~clk;

  physt_regs physt_regs_i (.clk(clk), .rst(rst), .strap_pins(strap_pins), .cond_in(cond_in),
                           .req(req), .rdata_r(rdata_r), .strap_r(strap_r));
  physt_mgmt physt_mgmt_i (.clk(clk), .req(req), .rdata_r(rdata_r));

  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [15:0] strap_word(input physt_strap_t s);
    return {s.an_enable, s.duplex, s.speed, 1'b0, s.nc_mode, 2'b00, s.mac_clk_enable,
            s.auto_crossover_strap, s.multi_port, s.station_address_straps};
  endfunction

  function automatic logic [15:0] cond_word(input physt_cond_t k, input logic f);
    return {k.pair_polarity_flags, k.power_down, k.crossover_state, f, 1'b0, k.shallow_loopback,
            k.deep_loopback, k.nc_only, k.speed, k.link_up, k.full_duplex, k.master};
  endfunction

  task report_and_stop;
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask

  task chk_strap(input physt_strap_t got, input physt_strap_t exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: straps %h, wanted %h", $time, got, exp);
    end
  endtask

  // Reset with new straps; strap_r must show defaults, then the new pins.
  task restrap(input physt_strap_t s);
    @(posedge clk);
    strap_pins <= s;
    rst        <= 1'b1;
    repeat (6) @(posedge clk);
    chk_strap(strap_r, STRAP_RST);
    chk_word(rdata_r, 16'h0000);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_strap(strap_r, s);
  endtask

  task put(input physt_cond_t k);
    @(posedge clk);
    cond_in <= k;
  endtask

  // A hang is cut short here and counted as a mismatch.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles > 20000)
    begin
      errors++;
      $display("unexpected at %0t: run too long", $time);
      report_and_stop;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed        = 32'he7c35a0d;
    rst         = 1'b1;
    strap_pins  = STRAP_RST;
    cond_in     = '0;
    errors      = 0;
    checks_done = 0;
    for (i = 0; i < 6; i++)
    begin
      p = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : 13'($random(seed));
      restrap(p);
      physt_mgmt_i.rd(OFF_STRAP, d);
      chk_word(d, strap_word(p));
      physt_mgmt_i.wr(OFF_STRAP, 16'($random(seed)));
      strap_pins <= ~p;
      physt_mgmt_i.rd(OFF_STRAP, d);
      chk_word(d, strap_word(p));
      chk_strap(strap_r, p);
    end
    physt_mgmt_i.wr(5'h03, 16'($random(seed)));
    physt_mgmt_i.rd(5'h03, d);
    chk_word(d, 16'h0000);
    @(posedge clk);
    chk_word(rdata_r, 16'h0000);
    for (i = 0; i < 16; i++)
    begin
      c = 16'($random(seed));
      c.fifo_overflow = 1'b0;
      c.fifo_underrun = 1'b0;
      c.speed = 2'(i % 3);
      if (i == 0) c.pair_polarity_flags = 4'ha;
      put(c);
      physt_mgmt_i.rd(OFF_COND, d);
      chk_word(d, cond_word(c, 1'b0));
    end
    physt_mgmt_i.wr(OFF_COND, 16'hffff);
    physt_mgmt_i.rd(OFF_COND, d);
    chk_word(d, cond_word(c, 1'b0));
    c.link_up = 1'b1;
    c.fifo_overflow = 1'b1;
    put(c);
    physt_mgmt_i.rd(OFF_COND, d);
    chk_word(d, cond_word(c, 1'b1));
    c.fifo_overflow = 1'b0;
    put(c);
    physt_mgmt_i.rd(OFF_COND, d);
    chk_word(d, cond_word(c, 1'b1));
    physt_mgmt_i.rd(OFF_COND, d);
    chk_word(d, cond_word(c, 1'b1));
    c.link_up = 1'b0;
    put(c);
    physt_mgmt_i.rd(OFF_COND, d);
    chk_word(d, cond_word(c, 1'b0));
    c.link_up = 1'b1;
    put(c);
    c.link_up = 1'b0;
    c.fifo_underrun = 1'b1;
    put(c);
    c.fifo_underrun = 1'b0;
    put(c);
    physt_mgmt_i.rd(OFF_COND, d);
    chk_word(d, cond_word(c, 1'b1));
    report_and_stop;
  end
endmodule
